// *** mco_pkg.sv ***
package mco_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [6:0] MCO_ADDR_CTRL     = 7'h0A;
	localparam logic [7:0] MCO_CTRL_RESET    = 8'h06;
	localparam int         MCO_MCLK_LSB      = 0;
	localparam int         MCO_ENLF_BIT      = 3;
	localparam int         MCO_TAIL_LSB      = 4;
	localparam logic [7:0] MCO_CTRL_RW_MASK  = 8'h3F;

	// ------------------------------------------------------------
	// Clock options
	// ------------------------------------------------------------
	localparam int         MCO_DIV_W         = 6;
	localparam int         MCO_TAIL_W        = 10;
	localparam logic [2:0] MCO_MCLK_LF       = 3'h7;
	localparam int         MCO_XTAL_KHZ      = 30000;
	localparam int         MCO_F0_KHZ        = 30000;
	localparam int         MCO_F1_KHZ        = 15000;
	localparam int         MCO_F2_KHZ        = 10000;
	localparam int         MCO_F3_KHZ        = 4000;
	localparam int         MCO_F4_KHZ        = 3000;
	localparam int         MCO_F5_KHZ        = 2000;
	localparam int         MCO_F6_KHZ        = 1000;
	localparam int         MCO_TAIL1_CYC     = 128;
	localparam int         MCO_TAIL2_CYC     = 256;
	localparam int         MCO_TAIL3_CYC     = 512;
	localparam logic [MCO_DIV_W-1:0] MCO_LF_HALF = 6'h01;

	typedef enum logic [1:0] {MCO_SRC_XTAL, MCO_SRC_LF} mco_src_t;
	typedef enum logic [1:0] {MCO_RUN, MCO_TAIL, MCO_LFOUT, MCO_STOPPED} mco_state_t;

	// Output period in crystal edges (both edges counted)
	function automatic int mco_period_edges(input logic [2:0] sel);
		int f;
		begin
			f = MCO_F6_KHZ;
			case (sel)
				3'h0: f = MCO_F0_KHZ;
				3'h1: f = MCO_F1_KHZ;
				3'h2: f = MCO_F2_KHZ;
				3'h3: f = MCO_F3_KHZ;
				3'h4: f = MCO_F4_KHZ;
				3'h5: f = MCO_F5_KHZ;
				default: f = MCO_F6_KHZ;
			endcase
			mco_period_edges = (2 * MCO_XTAL_KHZ) / f;
		end
	endfunction

	function automatic logic [MCO_DIV_W-1:0] mco_lo_len(input logic [2:0] sel);
		mco_lo_len = MCO_DIV_W'(mco_period_edges(sel) / 2);
	endfunction

	function automatic logic [MCO_DIV_W-1:0] mco_hi_len(input logic [2:0] sel);
		mco_hi_len = MCO_DIV_W'(mco_period_edges(sel) - mco_period_edges(sel) / 2);
	endfunction

	function automatic logic [MCO_TAIL_W-1:0] mco_tail_len(input logic [1:0] t);
		begin
			mco_tail_len = '0;
			case (t)
				2'h1: mco_tail_len = MCO_TAIL_W'(MCO_TAIL1_CYC);
				2'h2: mco_tail_len = MCO_TAIL_W'(MCO_TAIL2_CYC);
				2'h3: mco_tail_len = MCO_TAIL_W'(MCO_TAIL3_CYC);
				default: mco_tail_len = '0;
			endcase
		end
	endfunction

endpackage

// *** mco_divider.sv ***
`timescale 1ns/1ps
module mco_divider
	import mco_pkg::*;
#(
	parameter int W = MCO_DIV_W
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Control
	input  wire logic         tick,
	input  wire logic         run,
	input  wire logic         restart,
	input  wire logic [W-1:0] hi_len,
	input  wire logic [W-1:0] lo_len,
	// Output
	output logic              level,
	output logic              done
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic [W-1:0] hi;
		logic [W-1:0] lo;
		logic         lvl;
		logic         done;
	} mco_div_t;

	mco_div_t s_q;
	mco_div_t s_d;

	always_comb
	begin
		s_d      = s_q;
		s_d.done = 1'b0;
		if (restart)
		begin
			// Restart low so a switched-in source never starts with a short high
			s_d.cnt = '0;
			s_d.lvl = 1'b0;
			s_d.hi  = hi_len;
			s_d.lo  = lo_len;
		end
		else if (tick && run)
		begin
			s_d.cnt = s_q.cnt + W'(1);
			if (s_q.lvl && (s_q.cnt + W'(1) >= s_q.hi))
			begin
				s_d.cnt = '0;
				s_d.lvl = 1'b0;
			end
			else if (!s_q.lvl && (s_q.cnt + W'(1) >= s_q.lo))
			begin
				// Ratio is picked up only at the period boundary or on restart
				s_d.cnt  = '0;
				s_d.lvl  = 1'b1;
				s_d.done = 1'b1;
				s_d.hi   = hi_len;
				s_d.lo   = lo_len;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_q     <= '0;
			s_q.hi  <= W'(1);
			s_q.lo  <= W'(1);
		end
		else
			s_q <= s_d;
	end

	assign level = s_q.lvl;
	assign done  = s_q.done;

endmodule // mco_divider

// *** mco_clock_out.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Divided clocks come from the crystal.
// - Reset leaves 1 MHz on pin two.
// - Select field picks one of eight frequencies.
// - Low-frequency clock uses the selected 32k source.
// - Idle and receive output the selected frequency.
// - Crystal is switched off in sleep.
// - Sleep with low-frequency enable outputs 32k.
// - Sleep without it stops the clock.
// - Tail field adds 0/128/256/512 cycles first.
// - Pending interrupt keeps the clock running.
// - Read interrupt releases the commanded mode at the next output period boundary.
// - Watch-crystal select swaps RC for external 32k.
// - Wake-up timer interrupt re-enables the crystal.
module mco_clock_out
	import mco_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Register access
	input  wire logic       reg_wr_en,
	input  wire logic       reg_rd_en,
	input  wire logic [6:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// Oscillator edges, one pulse per edge, and 32k source select
	input  wire logic       xtal_edge,
	input  wire logic       lf_rc_edge,
	input  wire logic       lf_ext_edge,
	input  wire logic       external_watch_crystal_select,
	// Mode and interrupt state
	input  wire logic       mode_sleep,
	input  wire logic       interrupt_request_n,
	input  wire logic       wakeup_timer_irq,
	// Outputs
	output logic            general_io_pin_two,
	output logic            xtal_enable,
	output logic            clock_stopped
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]            ctrl;
		logic [7:0]            rdata;
		mco_state_t            st;
		mco_src_t              src;
		logic [MCO_TAIL_W-1:0] tail_cnt;
		logic                  wake;
		logic                  pin;
		logic                  xen;
		logic                  stopped;
		logic                  rst_x;
		logic                  rst_l;
	} mco_clk_t;

	mco_clk_t s_q;
	mco_clk_t s_d;

	logic [2:0] mclk_sel;
	logic       enlf;
	logic [1:0] tail_sel;
	logic       lf_edge;
	logic       x_level;
	logic       x_done;
	logic       l_level;
	logic       l_done;
	logic       src_done;
	logic       src_level;
	logic       sleep_eff;
	mco_src_t   want_src;

	assign mclk_sel = s_q.ctrl[MCO_MCLK_LSB +: 3];
	assign enlf     = s_q.ctrl[MCO_ENLF_BIT];
	assign tail_sel = s_q.ctrl[MCO_TAIL_LSB +: 2];

	assign lf_edge = external_watch_crystal_select ? lf_ext_edge : lf_rc_edge;

	// ------------------------------------------------------------
	// Clock generators
	// ------------------------------------------------------------
	// Integer crystal division
	mco_divider #(
		.W       (MCO_DIV_W)
	) u_xtal_div (
		.clk     (clk),
		.srst    (srst),
		.tick    (xtal_edge),
		.run     (s_q.xen),
		.restart (s_q.rst_x),
		.hi_len  (mco_hi_len(mclk_sel)),
		.lo_len  (mco_lo_len(mclk_sel)),
		.level   (x_level),
		.done    (x_done)
	);

	mco_divider #(
		.W       (MCO_DIV_W)
	) u_lf_div (
		.clk     (clk),
		.srst    (srst),
		.tick    (lf_edge),
		.run     (1'b1),
		.restart (s_q.rst_l),
		.hi_len  (MCO_LF_HALF),
		.lo_len  (MCO_LF_HALF),
		.level   (l_level),
		.done    (l_done)
	);

	assign src_done  = (s_q.src == MCO_SRC_LF) ? l_done : x_done;
	assign src_level = (s_q.src == MCO_SRC_LF) ? l_level : x_level;

	// Top code selects the low-frequency clock
	assign want_src = (mclk_sel == MCO_MCLK_LF) ? MCO_SRC_LF : MCO_SRC_XTAL;

	// Pending interrupt or wake-up holds the clock
	// Sleep waits until the host has cleared interrupts
	// Wake-up pulse acts at once, so the crystal and the clock come back together
	assign sleep_eff = mode_sleep && interrupt_request_n && !s_q.wake && !wakeup_timer_irq;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_d       = s_q;
		s_d.rst_x = 1'b0;
		s_d.rst_l = 1'b0;

		if (reg_wr_en && (reg_addr == MCO_ADDR_CTRL))
			s_d.ctrl = reg_wdata & MCO_CTRL_RW_MASK;
		if (reg_rd_en)
			s_d.rdata = (reg_addr == MCO_ADDR_CTRL) ? s_q.ctrl : 8'h00;

		// Wake-up event wins over its clear
		if (wakeup_timer_irq)
			s_d.wake = 1'b1;
		else if (!interrupt_request_n)
			s_d.wake = 1'b0;

		unique case (s_q.st)
			MCO_RUN:
			begin
				if (src_done)
				begin
					if (sleep_eff && enlf)
					begin
						s_d.st    = MCO_LFOUT;
						s_d.src   = MCO_SRC_LF;
						s_d.rst_l = (s_q.src != MCO_SRC_LF);
					end
					else if (sleep_eff && (mco_tail_len(tail_sel) == '0))
						s_d.st = MCO_STOPPED;
					else if (sleep_eff)
					begin
						s_d.st       = MCO_TAIL;
						s_d.tail_cnt = '0;
					end
					else if (want_src != s_q.src)
					begin
						s_d.src   = want_src;
						s_d.rst_x = (want_src == MCO_SRC_XTAL);
						s_d.rst_l = (want_src == MCO_SRC_LF);
					end
				end
			end
			MCO_TAIL:
			begin
				if (!sleep_eff)
					s_d.st = MCO_RUN;
				else if (src_done)
				begin
					s_d.tail_cnt = s_q.tail_cnt + MCO_TAIL_W'(1);
					if (s_q.tail_cnt + MCO_TAIL_W'(1) >= mco_tail_len(tail_sel))
						s_d.st = MCO_STOPPED;
				end
			end
			MCO_LFOUT:
			begin
				if (l_done && (!sleep_eff || !enlf))
				begin
					s_d.st    = sleep_eff ? MCO_STOPPED : MCO_RUN;
					s_d.src   = want_src;
					s_d.rst_x = 1'b1;
					s_d.rst_l = 1'b1;
				end
			end
			MCO_STOPPED:
			begin
				// Leave sleep as soon as allowed
				if (!sleep_eff || enlf)
				begin
					s_d.st    = sleep_eff ? MCO_LFOUT : MCO_RUN;
					s_d.src   = sleep_eff ? MCO_SRC_LF : want_src;
					s_d.rst_x = 1'b1;
					s_d.rst_l = 1'b1;
				end
			end
		endcase

		s_d.xen     = !((s_d.st == MCO_LFOUT) || (s_d.st == MCO_STOPPED)) || s_d.wake;
		s_d.stopped = (s_d.st == MCO_STOPPED);
		// Pin low while stopped or restarting
		// A stop taken at the boundary hides that rising edge, else a runt escapes
		s_d.pin     = (s_d.st == MCO_STOPPED || s_q.st == MCO_STOPPED || s_d.rst_x || s_d.rst_l ||
		               s_q.rst_x || s_q.rst_l) ? 1'b0 : src_level;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_q      <= '0;
			s_q.ctrl <= MCO_CTRL_RESET;
			s_q.st   <= MCO_RUN;
			s_q.src  <= MCO_SRC_XTAL;
			s_q.xen  <= 1'b1;
			s_q.rst_x <= 1'b1;
			s_q.rst_l <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign reg_rdata          = s_q.rdata;
	assign general_io_pin_two = s_q.pin;
	assign xtal_enable        = s_q.xen;
	assign clock_stopped      = s_q.stopped;

endmodule // mco_clock_out

// *** mco_clock_out_properties.sv ***
`timescale 1ns/1ps
module mco_clock_out_properties
	import mco_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       srst,
	// Register access
	input wire logic       reg_wr_en,
	input wire logic       reg_rd_en,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Mode and interrupt
	input wire logic       mode_sleep,
	input wire logic       interrupt_request_n,
	input wire logic       wakeup_timer_irq,
	// Outputs
	input wire logic       general_io_pin_two,
	input wire logic       xtal_enable,
	input wire logic       clock_stopped
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_reset_state: assert property (disable iff (1'b0)
		srst |=> !general_io_pin_two && xtal_enable && !clock_stopped && reg_rdata == 8'h00)
		else $error("outputs wrong after reset");
	a_write_read: assert property (
		reg_wr_en && reg_addr == MCO_ADDR_CTRL ##1 !reg_wr_en
		##1 reg_rd_en && !reg_wr_en && reg_addr == MCO_ADDR_CTRL
		|=> reg_rdata == ($past(reg_wdata, 3) & MCO_CTRL_RW_MASK))
		else $error("control readback wrong");
	a_unmapped_zero: assert property (reg_rd_en && reg_addr != MCO_ADDR_CTRL |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	// Stop only in the low phase, so no runt pulse
	a_stop_low: assert property (clock_stopped |-> !general_io_pin_two)
		else $error("pin high while stopped");
	a_sleep_xtal_off: assert property (clock_stopped ##1 clock_stopped |-> !xtal_enable)
		else $error("crystal on while stopped");
	a_irq_runs: assert property (!interrupt_request_n [*2] |-> !clock_stopped)
		else $error("clock stopped with interrupt pending");
	a_wake_xtal: assert property (wakeup_timer_irq |=> xtal_enable)
		else $error("wake-up did not enable crystal");
	a_awake_runs: assert property (!mode_sleep [*2] |-> !clock_stopped)
		else $error("clock stopped outside sleep");
	c_stopped: cover property ($rose(clock_stopped));
	c_wake: cover property (wakeup_timer_irq ##1 xtal_enable);
	c_irq_sleep: cover property (mode_sleep && !interrupt_request_n);
endmodule // mco_clock_out_properties

bind mco_clock_out mco_clock_out_properties u_props (.clk(clk), .srst(srst), .reg_wr_en(reg_wr_en),
	.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.mode_sleep(mode_sleep), .interrupt_request_n(interrupt_request_n), .wakeup_timer_irq(wakeup_timer_irq),
	.general_io_pin_two(general_io_pin_two), .xtal_enable(xtal_enable), .clock_stopped(clock_stopped));

// *** mco_host_model.sv ***
`timescale 1ns/1ps
module mco_host_model
#(
	parameter int READ_RISES = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Host clock and interrupt line
	input wire logic general_io_pin_two,
	input wire logic irq_raise,
	output logic     interrupt_request_n,
	// Observation
	output int       rises,
	output int       period
);
	logic pin_q;
	int   stamp;
	int   served;
	always_ff @(posedge clk)
	begin
		pin_q <= general_io_pin_two;
		stamp <= stamp + 1;
		if (general_io_pin_two && !pin_q)
		begin
			rises <= rises + 1;
			period <= stamp + 1;
			stamp <= 0;
		end
		// status read needs host clock edges
		if (irq_raise)
		begin
			interrupt_request_n <= 1'b0;
			served <= 0;
		end
		else if (!interrupt_request_n && general_io_pin_two && !pin_q)
		begin
			served <= served + 1;
			if (served == READ_RISES - 1)
				interrupt_request_n <= 1'b1;
		end
		if (srst)
		begin
			rises <= 0;
			period <= 0;
			interrupt_request_n <= 1'b1;
		end
	end
endmodule // mco_host_model

// *** test_mco_clock_out.sv ***
`timescale 1ns/1ps
module test_mco_clock_out;
	import mco_pkg::*;
	logic       clk = 1'b0, srst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rce = 1'b0, exe = 1'b0;
	logic       ext_sel = 1'b0, sleep = 1'b0, wake = 1'b0, irq_raise = 1'b0;
	logic [6:0] addr = 7'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic       pin, xen, stopped, irq_n;
	int         rises, period, n, lfc = 0;
	int         fails = 0, check_count = 0;
	int         edges[7] = '{2, 4, 6, 15, 20, 30, 60};
	int         tails[4] = '{0, 128, 256, 512};
	always #4 clk = ~clk;
	// Slow sources: RC an edge every 4 cycles, external every 6
	always @(negedge clk)
	begin
		lfc <= lfc + 1;
		rce <= (lfc % 4 == 0);
		exe <= (lfc % 6 == 0);
	end
	mco_clock_out dut (.clk(clk), .srst(srst), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata(rdata), .xtal_edge(1'b1), .lf_rc_edge(rce), .lf_ext_edge(exe),
		.external_watch_crystal_select(ext_sel), .mode_sleep(sleep), .interrupt_request_n(irq_n),
		.wakeup_timer_irq(wake), .general_io_pin_two(pin), .xtal_enable(xen), .clock_stopped(stopped));
	mco_host_model #(.READ_RISES(16)) host (.clk(clk), .srst(srst), .general_io_pin_two(pin),
		.irq_raise(irq_raise), .interrupt_request_n(irq_n), .rises(rises), .period(period));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		wr_en = 1'b1; addr = a; wdata = d;
		@(negedge clk);
		wr_en = 1'b0;
	endtask
	task rd(input logic [6:0] a, input logic [7:0] e);
		@(negedge clk);
		rd_en = 1'b1; addr = a;
		@(negedge clk);
		rd_en = 1'b0;
		check(32'(rdata), 32'(e));
	endtask
	task wait_stop(input int lim);
		for (int i = 0; i < lim && stopped !== 1'b1; i++) @(negedge clk);
	endtask
	task pulse_irq;
		@(negedge clk) irq_raise = 1'b1;
		@(negedge clk) irq_raise = 1'b0;
	endtask
	task tally_and_finish;
		$display("checks=%0d fails=%0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Tests need under 8000 cycles; the limit leaves wide margin
	initial
	begin
		repeat (60000) @(posedge clk);
		fails++;
		$display("watchdog expired");
		tally_and_finish;
	end
	initial
	begin
		cyc(10);
		srst = 1'b0;
		rd(MCO_ADDR_CTRL, 8'h06);
		cyc(200);
		check(period, 60);
		wr(MCO_ADDR_CTRL, 8'hFF);
		rd(MCO_ADDR_CTRL, 8'h3F);
		rd(7'h0B, 8'h00);
		$display("test registers done");
		for (int s = 0; s < 7; s++)
		begin
			wr(MCO_ADDR_CTRL, 8'(s));
			cyc(200);
			check(period, edges[s]);
		end
		wr(MCO_ADDR_CTRL, 8'h07);
		cyc(100);
		check(period, 8);
		ext_sel = 1'b1;
		cyc(100);
		check(period, 12);
		ext_sel = 1'b0;
		wr(MCO_ADDR_CTRL, 8'h08);
		sleep = 1'b1;
		cyc(100);
		check(period, 8);
		check(32'(xen), 32'h0);
		sleep = 1'b0;
		cyc(100);
		check(period, 2);
		$display("test select done");
		for (int t = 0; t < 4; t++)
		begin
			wr(MCO_ADDR_CTRL, 8'(t * 16));
			cyc(20);
			n = rises;
			sleep = 1'b1;
			wait_stop(1500);
			n = rises - n;
			check(32'(n >= tails[t] && n <= tails[t] + 1), 32'h1);
			check(32'(stopped), 32'h1);
			sleep = 1'b0;
			cyc(20);
			check(32'(stopped), 32'h0);
		end
		$display("test tail done");
		wr(MCO_ADDR_CTRL, 8'h00);
		pulse_irq;
		sleep = 1'b1;
		cyc(10);
		check(32'(stopped), 32'h0);
		wait_stop(200);
		check(32'(stopped), 32'h1);
		@(negedge clk) wake = 1'b1;
		@(negedge clk) wake = 1'b0;
		cyc(2);
		check(32'(xen), 32'h1);
		check(32'(stopped), 32'h0);
		pulse_irq;
		wait_stop(300);
		check(32'(stopped), 32'h1);
		sleep = 1'b0;
		$display("test interrupt done");
		tally_and_finish;
	end
endmodule // test_mco_clock_out
